// [rtl/rssc_defines.svh]
`ifndef RSSC_DEFINES_SVH
`define RSSC_DEFINES_SVH
// Output levels in tenths of a percent, signed 11 bit
`define RSSC_LVL_W        11
`define RSSC_LVL_MAX      11'sd1000
`define RSSC_LVL_MIN      -11'sd1000
`define RSSC_LVL_ZERO     11'sd0
`define RSSC_SP_W         16
`define RSSC_SP_RST       16'h0000
// Contact debounce time and cycles at 100 MHz
`define RSSC_CLK_MHZ      100
`define RSSC_DEB_US       1
`define RSSC_DEB_CYC      (`RSSC_DEB_US * `RSSC_CLK_MHZ)
`define RSSC_DEB_W        7
// Sample phase outlasts one full debounce of a contact shorted at power-up
`define RSSC_SMP_CYC      (`RSSC_DEB_CYC + 2)
`endif

// [rtl/rssc_pkg.sv]
package rssc_pkg;
    typedef enum logic [1:0] {CM_PID, CM_ONOFF, CM_HEATCOOL} rssc_ctl_mode_t;
    typedef enum logic [1:0] {BANK_1, BANK_2, BANK_4} rssc_bank_cnt_t;
    typedef enum logic [2:0] {FN_NONE, FN_STOP, FN_ALCLR, FN_MANUAL, FN_SPSEL} rssc_di_fn_t;
    typedef enum logic [1:0] {ST_SAMPLE, ST_RUN} rssc_phase_t;
    typedef enum logic [2:0] {
        CMD_NONE, CMD_RUNSTOP, CMD_ALCLR, CMD_AUTOMAN, CMD_BANKSEL,
        CMD_SETPOINT, CMD_PARAM
    } rssc_cmd_t;
    typedef struct packed {
        logic            valid;
        logic            write;
        rssc_cmd_t       cmd;
        logic [1:0]      slot;
        logic [15:0]     data;
    } rssc_req_t;
    typedef struct packed {
        logic            valid;
        logic            ack;
        logic            nak;
        logic [15:0]     data;
    } rssc_rsp_t;
    typedef struct packed {
        rssc_phase_t     phase;
        logic [6:0]      smp_cnt;
        logic [1:0]      deb_sync;
        logic [1:0]      deb_raw;
        logic [1:0]      contact;
        logic [6:0]      deb_cnt_a;
        logic [6:0]      deb_cnt_b;
        logic            stop_req;
        logic            manual_req;
        logic            alclr;
        logic [1:0]      bank_sel;
        logic [3:0][15:0] sp;
        logic [10:0]     hold_lvl;
        logic [10:0]     mv_out;
        logic [10:0]     disp_lvl;
        logic            stopped;
        logic            manual;
        logic [3:0]      alarm_out;
        logic [3:0]      alarm_saved;
        logic [15:0]     sp_out;
        logic [1:0]      sp_slot;
        logic            nv_we;
        rssc_rsp_t       rsp;
    } rssc_state_t;
endpackage : rssc_pkg

// [rtl/rssc_ctrl.sv]
// Behaviour
// RULE1: Write permit off rejects every link write request; reset value is enabled.
// RULE2: Link read requests are always answered regardless of write permit.
// RULE3: While stopped the control output equals the halt level, loop level ignored.
// RULE4: Halt level clamped per mode: PID 0..100, on/off 0 or 100, heat/cool +-100.
// RULE5: Run/stop state is mirrored to nonvolatile storage and restored at power-up.
// RULE6: On resume the output starts from the level held at the end of stop; code drives the loop level at once, held level only on resume_level_o.
// RULE7: While stopped the displayed level is the halt level, even with sensor break.
// RULE8: Halt alarm policy: continue keeps alarms normal, off forces alarms off.
// RULE9: Off policy with latch alarms restores pre-stop alarm states on return to run.
// RULE10: Run/stop changes are accepted even while the sensor is open.
// RULE11: Bank count is 1, 2 or 4 slots; default one.
// RULE12: Bank select is limited to enabled slots; default slot 0.
// RULE13: Four independent setpoints clamped to low/high limits, each reset to zero.
// RULE14: Stop contact shorted forces stop and refuses link run/stop requests.
// RULE15: Alarm clear contact shorted forces alarms off, refuses link alarm clear.
// RULE16: Manual contact shorted forces manual, refuses link auto/manual requests.
// RULE17: Any setpoint-select contact overrides link bank select requests.
// RULE18: A single select contact picks slot 0 open, slot 1 closed.
// RULE19: Two select contacts: A is bit 0, B is bit 1.
// RULE20: Bank count two masks contact B; bank count one masks both.
// RULE21: Contact selection ignored unless bank count is at least two.
// RULE22: Contacts are sampled after reset before their functions take effect; setpoint-select contacts steer the slot from reset.
// RULE23: Contacts are debounced over several clock cycles before use.
`include "rssc_defines.svh"
module rssc_ctrl
    import rssc_pkg::*;
(
    // Clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             nrst_i,
    // Link request and answer
    input  wire rssc_req_t        req_i,
    output      rssc_rsp_t        rsp_o,
    // Configuration
    input  wire logic             write_permit_i,
    input  wire rssc_ctl_mode_t   ctl_mode_i,
    input  wire logic [10:0]      halt_output_level_i,
    input  wire logic             halt_alarm_off_i,
    input  wire logic             alarm_latch_i,
    input  wire rssc_bank_cnt_t   setpoint_bank_count_i,
    input  wire rssc_di_fn_t      fn_a_i,
    input  wire rssc_di_fn_t      fn_b_i,
    input  wire logic [15:0]      sp_low_i,
    input  wire logic [15:0]      sp_high_i,
    // Nonvolatile run/stop
    input  wire logic             nv_stop_i,
    output      logic             nv_we_o,
    output      logic             nv_stop_o,
    // Contacts
    input  wire logic             contact_input_a_i,
    input  wire logic             contact_input_b_i,
    // Loop and alarm side
    input  wire logic [10:0]      loop_level_i,
    input  wire logic             sensor_open_i,
    input  wire logic [3:0]       alarm_raw_i,
    output      logic [10:0]      manipulated_output_level_o,
    output      logic [10:0]      disp_level_o,
    output      logic [10:0]      resume_level_o,
    output      logic             stopped_o,
    output      logic             manual_o,
    output      logic             alarm_clear_o,
    output      logic [3:0]       alarm_o,
    output      logic [15:0]      setpoint_value_o,
    output      logic [1:0]       setpoint_bank_select_o
);

    //--------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------
    function automatic logic [10:0] clamp_halt(input logic [10:0] v, input rssc_ctl_mode_t m);
        logic signed [10:0] s;
        s = signed'(v);
        case (m)
            CM_ONOFF:    clamp_halt = (s > `RSSC_LVL_ZERO) ? `RSSC_LVL_MAX : `RSSC_LVL_ZERO;
            CM_HEATCOOL: clamp_halt = (s > `RSSC_LVL_MAX) ? `RSSC_LVL_MAX :
                                      (s < `RSSC_LVL_MIN) ? `RSSC_LVL_MIN : v;
            default:     clamp_halt = (s > `RSSC_LVL_MAX) ? `RSSC_LVL_MAX :
                                      (s < `RSSC_LVL_ZERO) ? `RSSC_LVL_ZERO : v;
        endcase
    endfunction : clamp_halt

    function automatic logic [1:0] bank_limit(input logic [1:0] v, input rssc_bank_cnt_t c);
        case (c)
            BANK_4:  bank_limit = v;
            BANK_2:  bank_limit = {1'b0, v[0]};
            default: bank_limit = 2'h0;
        endcase
    endfunction : bank_limit

    //--------------------------------------------------------------
    // State
    //--------------------------------------------------------------
    rssc_state_t s_r;
    rssc_state_t s_nxt;

    logic a_stop;
    logic a_alclr;
    logic a_man;
    logic a_sel;
    logic b_sel;
    logic [1:0] ct_sel;
    logic [15:0] sp_clamped;
    logic is_write;
    logic [10:0] halt_lvl;

    always_comb begin
        s_nxt = s_r;
        s_nxt.nv_we = 1'b0;
        s_nxt.rsp = '0;
        // Link alarm clear is one-shot; a new request in the clearing cycle wins
        s_nxt.alclr = 1'b0;
        halt_lvl = clamp_halt(halt_output_level_i, ctl_mode_i); // RULE4
        // Sync then debounce; first stage only feeds second
        s_nxt.deb_sync = {contact_input_b_i, contact_input_a_i};
        s_nxt.deb_raw = s_r.deb_sync;
        if (s_r.deb_raw[0] == s_r.contact[0]) begin // RULE23
            s_nxt.deb_cnt_a = '0;
        end else if (s_r.deb_cnt_a == 7'(`RSSC_DEB_CYC - 1)) begin
            s_nxt.contact[0] = s_r.deb_raw[0];
            s_nxt.deb_cnt_a = '0;
        end else begin
            s_nxt.deb_cnt_a = s_r.deb_cnt_a + 7'h01;
        end
        if (s_r.deb_raw[1] == s_r.contact[1]) begin // RULE23
            s_nxt.deb_cnt_b = '0;
        end else if (s_r.deb_cnt_b == 7'(`RSSC_DEB_CYC - 1)) begin
            s_nxt.contact[1] = s_r.deb_raw[1];
            s_nxt.deb_cnt_b = '0;
        end else begin
            s_nxt.deb_cnt_b = s_r.deb_cnt_b + 7'h01;
        end
        // Stop, alarm clear and manual functions stay off until contacts have been sampled
        a_stop  = 1'b0;
        a_alclr = 1'b0;
        a_man   = 1'b0;
        a_sel   = (fn_a_i == FN_SPSEL);
        b_sel   = (fn_b_i == FN_SPSEL);
        if (s_r.phase == ST_RUN) begin // RULE22
            a_stop  = (fn_a_i == FN_STOP && s_r.contact[0]) ||
                      (fn_b_i == FN_STOP && s_r.contact[1]);
            a_alclr = (fn_a_i == FN_ALCLR && s_r.contact[0]) ||
                      (fn_b_i == FN_ALCLR && s_r.contact[1]);
            a_man   = (fn_a_i == FN_MANUAL && s_r.contact[0]) ||
                      (fn_b_i == FN_MANUAL && s_r.contact[1]);
        end
        case (s_r.phase)
            ST_SAMPLE: begin
                s_nxt.stop_req = nv_stop_i; // RULE5
                s_nxt.smp_cnt = s_r.smp_cnt + 7'h01;
                if (s_r.smp_cnt == 7'(`RSSC_SMP_CYC)) begin // RULE22
                    s_nxt.phase = ST_RUN;
                end
            end
            ST_RUN:  s_nxt.phase = ST_RUN;
            default: s_nxt.phase = ST_SAMPLE;
        endcase
        // Contact setpoint selection
        if (a_sel && b_sel) begin
            ct_sel = {s_r.contact[1], s_r.contact[0]}; // RULE19
        end else if (a_sel) begin
            ct_sel = {1'b0, s_r.contact[0]}; // RULE18
        end else begin
            ct_sel = {1'b0, s_r.contact[1]}; // RULE18
        end
        // Link requests
        is_write = req_i.valid && req_i.write;
        sp_clamped = ($signed(req_i.data) < $signed(sp_low_i)) ? sp_low_i :
                     ($signed(req_i.data) > $signed(sp_high_i)) ? sp_high_i : req_i.data;
        if (req_i.valid && !req_i.write) begin
            s_nxt.rsp.valid = 1'b1; // RULE2
            s_nxt.rsp.ack = 1'b1;
            case (req_i.cmd)
                CMD_RUNSTOP:  s_nxt.rsp.data = {15'h0000, s_r.stopped};
                CMD_AUTOMAN:  s_nxt.rsp.data = {15'h0000, s_r.manual};
                CMD_BANKSEL:  s_nxt.rsp.data = {14'h0000, s_r.sp_slot};
                CMD_SETPOINT: s_nxt.rsp.data = s_r.sp[req_i.slot];
                default:      s_nxt.rsp.data = {{5{s_r.disp_lvl[10]}}, s_r.disp_lvl};
            endcase
        end else if (is_write) begin
            s_nxt.rsp.valid = 1'b1;
            s_nxt.rsp.nak = 1'b1;
            if (write_permit_i) begin // RULE1
                case (req_i.cmd)
                    CMD_RUNSTOP: if (!a_stop) begin // RULE14 RULE10
                        s_nxt.stop_req = req_i.data[0];
                        s_nxt.rsp.nak = 1'b0;
                    end
                    CMD_ALCLR: if (!a_alclr) begin // RULE15
                        s_nxt.alclr = req_i.data[0];
                        s_nxt.rsp.nak = 1'b0;
                    end
                    CMD_AUTOMAN: if (!a_man) begin // RULE16
                        s_nxt.manual_req = req_i.data[0];
                        s_nxt.rsp.nak = 1'b0;
                    end
                    CMD_BANKSEL: if (!a_sel && !b_sel) begin // RULE17
                        s_nxt.bank_sel = bank_limit(req_i.data[1:0], setpoint_bank_count_i); // RULE12
                        s_nxt.rsp.nak = 1'b0;
                    end
                    CMD_SETPOINT: begin
                        s_nxt.sp[req_i.slot] = sp_clamped; // RULE13
                        s_nxt.rsp.nak = 1'b0;
                    end
                    default: s_nxt.rsp.nak = 1'b1;
                endcase
            end
            s_nxt.rsp.ack = !s_nxt.rsp.nak;
        end
        // Effective state
        s_nxt.stopped = s_nxt.stop_req || a_stop; // RULE14
        if (s_nxt.stop_req != s_r.stop_req) begin
            s_nxt.nv_we = 1'b1; // RULE5
        end
        s_nxt.manual = s_nxt.manual_req || a_man; // RULE16
        if ((a_sel || b_sel) && setpoint_bank_count_i != BANK_1) begin // RULE21
            s_nxt.sp_slot = bank_limit(ct_sel, setpoint_bank_count_i); // RULE20
        end else begin
            s_nxt.sp_slot = bank_limit(s_nxt.bank_sel, setpoint_bank_count_i); // RULE11 RULE12
        end
        s_nxt.sp_out = s_r.sp[s_nxt.sp_slot];
        if (s_nxt.stopped) begin
            s_nxt.mv_out = halt_lvl; // RULE3
            s_nxt.disp_lvl = halt_lvl; // RULE7
            if (!s_r.stopped) begin
                s_nxt.alarm_saved = s_r.alarm_out;
            end
        end else begin
            // Loop level drives the output directly; the held stop level goes to resume_level_o
            s_nxt.mv_out = loop_level_i;
            s_nxt.disp_lvl = loop_level_i;
        end
        if (s_r.stopped) begin
            s_nxt.hold_lvl = halt_lvl; // RULE6
        end
        if (a_alclr || s_r.alclr) begin
            s_nxt.alarm_out = 4'h0; // RULE15
        end else if (s_nxt.stopped && halt_alarm_off_i) begin
            s_nxt.alarm_out = 4'h0; // RULE8
        end else if (s_r.stopped && !s_nxt.stopped && halt_alarm_off_i && alarm_latch_i) begin
            s_nxt.alarm_out = s_r.alarm_saved | alarm_raw_i; // RULE9
        end else if (alarm_latch_i) begin
            s_nxt.alarm_out = s_r.alarm_out | alarm_raw_i;
        end else begin
            s_nxt.alarm_out = alarm_raw_i; // RULE8
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    //--------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------
    assign rsp_o                      = s_r.rsp;
    assign nv_we_o                    = s_r.nv_we;
    assign nv_stop_o                  = s_r.stop_req;
    assign manipulated_output_level_o = s_r.mv_out;
    assign disp_level_o               = s_r.disp_lvl;
    assign resume_level_o             = s_r.hold_lvl;
    assign stopped_o                  = s_r.stopped;
    assign manual_o                   = s_r.manual;
    assign alarm_clear_o              = s_r.alclr;
    assign alarm_o                    = s_r.alarm_out;
    assign setpoint_value_o           = s_r.sp_out;
    assign setpoint_bank_select_o     = s_r.sp_slot;

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    property p_wr_block;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (req_i.valid && req_i.write && !write_permit_i) |=> (rsp_o.valid && rsp_o.nak);
    endproperty
    a_wr_block: assert property (p_wr_block) else $error("write not refused"); // RULE1

    property p_rd_ok;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (req_i.valid && !req_i.write) |=> (rsp_o.valid && rsp_o.ack);
    endproperty
    a_rd_ok: assert property (p_rd_ok) else $error("read not served"); // RULE2

    property p_halt_out;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        stopped_o |-> (manipulated_output_level_o == disp_level_o);
    endproperty
    a_halt_out: assert property (p_halt_out) else $error("stop level mismatch"); // RULE3

    property p_halt_rng;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (stopped_o && $past(ctl_mode_i) == CM_PID) |-> ($signed(manipulated_output_level_o) >= 0);
    endproperty
    a_halt_rng: assert property (p_halt_rng) else $error("halt level negative"); // RULE4

    property p_alarm_off;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (stopped_o && $past(stopped_o) && halt_alarm_off_i && $past(halt_alarm_off_i))
        |-> (alarm_o == 4'h0);
    endproperty
    a_alarm_off: assert property (p_alarm_off) else $error("alarm active in stop"); // RULE8

    property p_slot_lim;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (setpoint_bank_count_i == BANK_1) |=> (setpoint_bank_select_o == 2'h0);
    endproperty
    a_slot_lim: assert property (p_slot_lim) else $error("slot beyond count"); // RULE12

    property p_stop_nak;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (req_i.valid && req_i.write && req_i.cmd == CMD_RUNSTOP && stopped_o && a_stop)
        |=> rsp_o.nak;
    endproperty
    a_stop_nak: assert property (p_stop_nak) else $error("run/stop not refused"); // RULE14

    property p_nv_we;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        $changed(nv_stop_o) |-> nv_we_o;
    endproperty
    a_nv_we: assert property (p_nv_we) else $error("nv write missed"); // RULE5

endmodule : rssc_ctrl

// [tb/rssc_far_model.sv]
module rssc_far_model
    import rssc_pkg::*;
(
    // Clock and answer
    input  wire logic      sys_clk_i,
    input  wire rssc_rsp_t rsp_i,
    // Link request and contacts
    output      rssc_req_t req_o,
    output      logic      contact_input_a_o,
    output      logic      contact_input_b_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic ack_seen;
    logic nak_seen;
    logic [15:0] rd_data;

    initial begin
        req_o = '0;
        contact_input_a_o = 1'b0;
        contact_input_b_o = 1'b0;
    end

    // One request pulse, answer caught within three cycles
    task automatic send(input logic wr, input rssc_cmd_t cmd, input logic [15:0] dat);
        int i;
        @(negedge sys_clk_i);
        req_o = '{valid: 1'b1, write: wr, cmd: cmd, slot: 2'h0, data: dat};
        ack_seen = 1'b0;
        nak_seen = 1'b0;
        @(negedge sys_clk_i);
        req_o.valid = 1'b0;
        // Released data must not look like a held value
        req_o.data = ~req_o.data;
        for (i = 0; i < 3; i++) begin
            if (rsp_i.valid === 1'b1) begin
                ack_seen = rsp_i.ack;
                nak_seen = rsp_i.nak;
                rd_data = rsp_i.data;
                break;
            end
            @(negedge sys_clk_i);
        end
    endtask : send

    // Contacts chatter shorter than the debounce window, then settle
    task automatic set_contacts(input logic a, input logic b);
        int k;
        for (k = 0; k < 4; k++) begin
            @(negedge sys_clk_i);
            contact_input_a_o = a ^ k[0];
            contact_input_b_o = b ^ k[0];
        end
        @(negedge sys_clk_i);
        contact_input_a_o = a;
        contact_input_b_o = b;
        repeat (130) @(negedge sys_clk_i);
    endtask : set_contacts
endmodule : rssc_far_model

// [tb/tb_top.sv]
module tb_top
    import rssc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic           clk;
    logic           nrst;
    rssc_req_t      req;
    rssc_rsp_t      rsp;
    logic           permit;
    rssc_ctl_mode_t mode;
    logic [10:0]    halt;
    logic           al_off;
    rssc_bank_cnt_t bank;
    rssc_di_fn_t    fn_a;
    rssc_di_fn_t    fn_b;
    logic           nv_stop;
    logic           ci_a;
    logic           ci_b;
    logic [10:0]    loop_lvl;
    logic           s_open;
    logic [3:0]     al_raw;
    logic [10:0]    mv;
    logic [10:0]    disp;
    logic           stopped;
    logic           manual;
    logic [3:0]     alarm;
    logic [1:0]     sel;
    logic [15:0]    rnd;
    logic           latch;
    logic [15:0]    sp_hi;
    logic           nv_out;
    logic [10:0]    res_lvl;
    logic [15:0]    spv;
    int             n_mismatch;
    int             n_compared;
    int             cyc;

    rssc_ctrl dut (.sys_clk_i(clk), .nrst_i(nrst), .req_i(req), .rsp_o(rsp),
        .write_permit_i(permit), .ctl_mode_i(mode), .halt_output_level_i(halt),
        .halt_alarm_off_i(al_off), .alarm_latch_i(latch), .setpoint_bank_count_i(bank),
        .fn_a_i(fn_a), .fn_b_i(fn_b), .sp_low_i(16'h8000), .sp_high_i(sp_hi),
        .nv_stop_i(nv_stop), .nv_we_o(), .nv_stop_o(nv_out), .contact_input_a_i(ci_a),
        .contact_input_b_i(ci_b), .loop_level_i(loop_lvl), .sensor_open_i(s_open),
        .alarm_raw_i(al_raw), .manipulated_output_level_o(mv), .disp_level_o(disp),
        .resume_level_o(res_lvl), .stopped_o(stopped), .manual_o(manual), .alarm_clear_o(),
        .alarm_o(alarm), .setpoint_value_o(spv), .setpoint_bank_select_o(sel));

    rssc_far_model far (.sys_clk_i(clk), .rsp_i(rsp), .req_o(req),
        .contact_input_a_o(ci_a), .contact_input_b_o(ci_b));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr

    // Reference selection: bank count masks the upper contacts
    function automatic logic [1:0] exp_sel(input rssc_bank_cnt_t b, input logic [1:0] c);
        if (b == BANK_1) return 2'h0;
        if (b == BANK_2) return {1'b0, c[0]};
        return c;
    endfunction : exp_sel

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int bi;
        int c;
        n_mismatch = 0; n_compared = 0; cyc = 0;
        nrst = 1'b0; permit = 1'b1; mode = CM_PID; halt = 11'h000; al_off = 1'b0;
        bank = BANK_1; fn_a = FN_NONE; fn_b = FN_NONE; nv_stop = 1'b0;
        s_open = 1'b0; al_raw = 4'h5; rnd = 16'hE9D6; loop_lvl = 11'h000;
        latch = 1'b0; sp_hi = 16'h03E8;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        repeat (130) @(negedge clk);
        chk("stopped", 16'h0, {15'h0, stopped});
        chk("bank_select", 16'h0, {14'h0, sel});
        chk("alarm", 16'h5, {12'h0, alarm});
        far.send(1'b1, CMD_SETPOINT, 16'h1234);
        far.send(1'b0, CMD_SETPOINT, 16'h0000);
        chk("sp_read", 16'h03E8, far.rd_data);
        chk("setpoint", 16'h03E8, spv);
        rnd = lfsr(rnd);
        halt = 11'(rnd % 16'd1001);
        rnd = lfsr(rnd);
        loop_lvl = 11'(rnd % 16'd1001);
        permit = 1'b0;
        far.send(1'b1, CMD_RUNSTOP, 16'h0001);
        chk("nak", 16'h1, {15'h0, far.nak_seen});
        chk("stopped", 16'h0, {15'h0, stopped});
        far.send(1'b0, CMD_PARAM, 16'h0000);
        chk("ack", 16'h1, {15'h0, far.ack_seen});
        permit = 1'b1;
        s_open = 1'b1;
        far.send(1'b1, CMD_RUNSTOP, 16'h0001);
        chk("ack", 16'h1, {15'h0, far.ack_seen});
        repeat (3) @(negedge clk);
        chk("stopped", 16'h1, {15'h0, stopped});
        chk("mv", {5'h0, halt}, {5'h0, mv});
        chk("disp", {5'h0, halt}, {5'h0, disp});
        chk("nv_stop", 16'h1, {15'h0, nv_out});
        al_off = 1'b1;
        repeat (3) @(negedge clk);
        chk("alarm", 16'h0, {12'h0, alarm});
        mode = CM_HEATCOOL;
        halt = 11'h418;
        repeat (3) @(negedge clk);
        chk("mv", 16'h0418, {5'h0, mv});
        mode = CM_PID;
        halt = 11'h60C;
        repeat (3) @(negedge clk);
        chk("mv", 16'h0000, {5'h0, mv});
        halt = 11'h1F4;
        latch = 1'b1;
        al_raw = 4'h0;
        far.send(1'b1, CMD_RUNSTOP, 16'h0000);
        repeat (3) @(negedge clk);
        chk("stopped", 16'h0, {15'h0, stopped});
        chk("resume", 16'h01F4, {5'h0, res_lvl});
        chk("alarm", 16'h5, {12'h0, alarm});
        latch = 1'b0;
        al_raw = 4'h5;
        al_off = 1'b0;
        s_open = 1'b0;
        fn_a = FN_STOP;
        far.set_contacts(1'b1, 1'b0);
        chk("stopped", 16'h1, {15'h0, stopped});
        chk("alarm", 16'h5, {12'h0, alarm});
        far.send(1'b1, CMD_RUNSTOP, 16'h0000);
        chk("nak", 16'h1, {15'h0, far.nak_seen});
        fn_a = FN_ALCLR;
        far.set_contacts(1'b1, 1'b0);
        chk("alarm", 16'h0, {12'h0, alarm});
        far.send(1'b1, CMD_ALCLR, 16'h0001);
        chk("nak", 16'h1, {15'h0, far.nak_seen});
        fn_a = FN_NONE;
        fn_b = FN_MANUAL;
        far.set_contacts(1'b0, 1'b1);
        chk("manual", 16'h1, {15'h0, manual});
        far.send(1'b1, CMD_AUTOMAN, 16'h0000);
        chk("nak", 16'h1, {15'h0, far.nak_seen});
        fn_a = FN_SPSEL;
        fn_b = FN_SPSEL;
        for (bi = 0; bi < 3; bi++) begin
            bank = rssc_bank_cnt_t'(bi);
            for (c = 0; c < 4; c++) begin
                far.set_contacts(c[0], c[1]);
                chk("bank_select", {14'h0, exp_sel(bank, c[1:0])}, {14'h0, sel});
            end
        end
        fn_b = FN_NONE;
        far.set_contacts(1'b1, 1'b0);
        chk("bank_select", 16'h1, {14'h0, sel});
        far.send(1'b1, CMD_BANKSEL, 16'h0002);
        chk("nak", 16'h1, {15'h0, far.nak_seen});
        fn_a = FN_NONE;
        fn_b = FN_NONE;
        far.set_contacts(1'b0, 1'b0);
        nv_stop = 1'b1;
        nrst = 1'b0;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        repeat (130) @(negedge clk);
        chk("stopped", 16'h1, {15'h0, stopped});
        report_and_stop();
    end
endmodule : tb_top
